// file: dv/nvs_array_model.sv
`timescale 1ns/100ps
module nvs_array_model #(
  parameter int DQ_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // request side
  input wire logic arrayReq,
  input wire logic [nvs_pkg::ARR_W-1:0] arrayAddr,
  input wire logic slow,
  // answer side
  output logic arrayRdValid,
  output logic [DQ_W-1:0] arrayRdData
);
  import nvs_pkg::*;
  logic v1_q;
  logic v2_q;
  logic [ARR_W-1:0] a1_q;
  logic [ARR_W-1:0] a2_q;
  logic [DQ_W-1:0] last_q;
  logic [ARR_W-1:0] a;
  // slow answers one edge later; idle lines show the inverse of the last word
  always_ff @(posedge mclk) begin
    v1_q <= arrayReq && rst_b;
    a1_q <= arrayAddr;
    v2_q <= v1_q;
    a2_q <= a1_q;
    last_q <= arrayRdData;
  end
  assign a = slow ? a2_q : a1_q;
  assign arrayRdValid = slow ? v2_q : v1_q;
  assign arrayRdData = arrayRdValid ? DQ_W'(a[21:6] ^ {a[7:0], a[7:0]}) : ~last_q;
endmodule : nvs_array_model

// file: dv/nvs_top_props.sv
`timescale 1ns/100ps
module nvs_top_props #(
  parameter int DQ_W = 16,
  parameter int INIT_CYCLES = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // command side
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic bank_select_0,
  input wire logic bank_select_1,
  input wire logic [nvs_pkg::ADDR_W-1:0] addr,
  input wire logic power_down_reset_n,
  input wire logic [DQ_W-1:0] dqIn,
  // device side
  input wire logic dqOeN,
  input wire logic arrayReq,
  input wire logic arrayWe,
  input wire logic [nvs_pkg::ARR_W-1:0] arrayAddr,
  input wire logic [DQ_W-1:0] arrayWrData,
  input wire logic statusReady
);
  import nvs_pkg::*;
  localparam int INIT_MAX = INIT_CYCLES + 8;
  localparam logic [ROW_W-1:0] RMASK = (DQ_W == 32) ? ROW_MASK_X32 : ROW_MASK_X16;
  logic [3:0] pins;
  logic [15:0] waitCnt_q;
  logic [13:0] actBr_q;
  logic [7:0] rdCol_q;
  logic [7:0] wrCol_q;
  logic [DQ_W-1:0] wrDat_q;
  assign pins = {csN, rasN, casN, weN};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // a counter, since the real init span is far beyond any delay range
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_q <= '0;
    end else if (statusReady || !power_down_reset_n) begin
      waitCnt_q <= '0;
    end else begin
      waitCnt_q <= waitCnt_q + 16'h0001;
    end
  end
  // commands taken while ready
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      actBr_q <= '0;
      rdCol_q <= '0;
      wrCol_q <= '0;
      wrDat_q <= '0;
    end else if (statusReady) begin
      if (pins == 4'b0011) begin
        actBr_q <= {bank_select_1, bank_select_0, addr};
      end
      if (pins == 4'b0101) begin
        rdCol_q <= addr[7:0];
      end
      if (pins == 4'b0100) begin
        wrCol_q <= addr[7:0];
        wrDat_q <= dqIn;
      end
    end
  end
  a_reset_quiet: assert property ($rose(rst_b) |-> dqOeN && !arrayReq && !statusReady)
    else $error("outputs active right after reset");
  a_pin_down: assert property (!power_down_reset_n [*4] |=> !statusReady)
    else $error("ready while held in power-down");
  a_init_bound: assert property (waitCnt_q <= INIT_MAX)
    else $error("initialization too long");
  a_read_column: assert property ($rose(arrayReq) |-> arrayAddr[7:0] == rdCol_q)
    else $error("first read column wrong");
  a_active_row: assert property (arrayReq |->
    arrayAddr[21:8] == {actBr_q[13:12], actBr_q[11:0] & RMASK})
    else $error("bank or row differs from active");
  a_busy_quiet: assert property (!statusReady |-> !arrayReq && !arrayWe)
    else $error("array access while not ready");
  a_init_cmd: assert property (statusReady && pins == 4'b0001 && addr[7:0] == CODE_INIT
    |-> ##[1:4] !statusReady)
    else $error("init code did not start init");
  a_write_first: assert property ($rose(arrayWe) |->
    arrayAddr[7:0] == wrCol_q && arrayWrData == wrDat_q)
    else $error("first write beat wrong");
  cover property ($rose(arrayReq));
  cover property ($rose(arrayWe));
  cover property ($rose(statusReady));
endmodule : nvs_top_props
bind nvs_top nvs_top_props #(.DQ_W(DQ_W), .INIT_CYCLES(INIT_CYCLES)) u_props (
  .mclk, .rst_b, .csN, .rasN, .casN, .weN, .bank_select_0, .bank_select_1, .addr,
  .power_down_reset_n, .dqIn, .dqOeN, .arrayReq, .arrayWe, .arrayAddr, .arrayWrData,
  .statusReady);

// file: dv/nvs_top_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED at %0t: %h not %h", $time, g, e); end end
module nvs_top_tb;
  import nvs_pkg::*;
  localparam int INIT_N = 20;
  logic mclk, rst_b, power_down_reset_n, slow, dqOeN, arrayReq, arrayWe, arrayRdValid;
  logic statusReady;
  logic [3:0] pins;
  logic [1:0] bank;
  logic [11:0] addr;
  logic [15:0] dqIn, dqOut, arrayWrData, arrayRdData;
  logic [ARR_W-1:0] arrayAddr;
  logic [2:0] wbl[4] = '{BL_4, BL_4, BL_FULL, BL_2};
  logic wbm[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int wlen[4] = '{4, 1, 8, 2};
  int bad_count = 0;
  int tests_run = 0;
  int weCnt = 0;
  int n;
  logic [15:0] got[$];
  time firstT;
  nvs_top #(.DQ_W(16), .INIT_CYCLES(INIT_N)) uut (
    .mclk, .rst_b, .csN(pins[3]), .rasN(pins[2]), .casN(pins[1]), .weN(pins[0]),
    .bank_select_0(bank[0]), .bank_select_1(bank[1]), .addr, .power_down_reset_n,
    .dqIn, .dqOut, .dqOeN, .arrayReq, .arrayWe, .arrayAddr, .arrayWrData,
    .arrayRdValid, .arrayRdData, .statusReady);
  nvs_array_model #(.DQ_W(16)) u_array (
    .mclk, .rst_b, .arrayReq, .arrayAddr, .slow, .arrayRdValid, .arrayRdData);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    if (dqOeN === 1'b0) begin
      if (got.size() == 0) firstT = $time;
      got.push_back(dqOut);
    end
    if (arrayWe === 1'b1) weCnt++;
  end
  function automatic logic [15:0] datOf(input logic [ARR_W-1:0] a);
    return a[21:6] ^ {a[7:0], a[7:0]};
  endfunction : datOf
  function automatic logic [7:0] colAt(input logic [7:0] s, i, m, input logic il);
    return (s & ~m) | ((il ? (s ^ i) : s + i) & m);
  endfunction : colAt
  function automatic logic [11:0] mk(input logic [2:0] bl, input logic il,
                                     input logic [1:0] opm, input logic wb);
    return {2'b00, wb, opm, 3'(1 + $urandom % 3), il, bl};
  endfunction : mk
  task automatic idle(input int c);
    pins = 4'b1111;
    repeat (c) @(posedge mclk);
    #1;
  endtask : idle
  task automatic issue(input logic [3:0] p, input logic [11:0] a, input logic [15:0] d = '0);
    pins = p;
    addr = a;
    dqIn = d;
    @(posedge mclk);
    #1;
  endtask : issue
  task automatic setMode(input logic [11:0] m);
    issue(4'b0000, m);
    idle(3);
  endtask : setMode
  task automatic waitReady(output int c);
    c = 0;
    while (statusReady !== 1'b1 && c < INIT_N + 40) begin
      @(posedge mclk);
      #1 c++;
    end
  endtask : waitReady
  // bt above zero ends a full-page burst early, so only the order is exact
  task automatic readRun(input logic il, input logic [7:0] col, input int len,
                         input int bt, input int expN);
    logic [1:0] b;
    logic [11:0] r;
    time t0;
    b = 2'($urandom);
    r = 12'($urandom);
    slow = 1'($urandom);
    bank = b;
    issue(4'b0011, r);
    got.delete();
    issue(4'b0101, {4'h0, col});
    t0 = $time - 1;
    if (bt > 0) begin
      idle(bt);
      issue(4'b0110, 12'h000);
    end
    idle(len % 256 + 16);
    if (bt > 0) begin
      `CHK(got.size() inside {[bt - 1:bt + 8]}, 1'b1)
      expN = got.size();
    end else begin
      `CHK(got.size(), expN)
    end
    for (int i = 0; i < expN && i < got.size(); i++) begin
      `CHK(got[i], datOf({b, r, colAt(col, 8'(i), 8'(len - 1), il)}))
    end
    // array answer, fifo store and output register put the first word six edges out
    if (!slow && expN > 0) `CHK(firstT, t0 + 26)
    $display("read burst of %0d done", expN);
  endtask : readRun
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  initial begin
    pins = 4'b1111;
    bank = 2'b00;
    addr = '0;
    dqIn = '0;
    rst_b = 1'b0;
    power_down_reset_n = 1'b1;
    slow = 1'b0;
    void'($urandom(32'hbe70_1b0a));
    repeat (12) @(posedge mclk);
    #1 rst_b = 1'b1;
    waitReady(n);
    `CHK(n < INIT_N + 8, 1'b1)
    for (int k = 0; k < 8; k++) begin
      setMode(mk(3'(k % 4), 1'(k / 4), 2'b00, 1'b0));
      readRun(1'(k / 4), 8'($urandom), 1 << (k % 4), 0, 1 << (k % 4));
    end
    setMode(mk(BL_8, 1'b1, 2'b00, 1'b0));
    readRun(1'b1, 8'hFF, 8, 0, 8);
    setMode(mk(BL_FULL, 1'b0, 2'b00, 1'b0));
    readRun(1'b0, 8'hFD, 256, 7, 0);
    setMode(mk(BL_4, 1'b0, 2'b01, 1'b0));
    readRun(1'b0, 8'h10, 4, 0, 0);
    setMode(mk(BL_2, 1'b0, 2'b00, 1'b0));
    issue(4'b0001, {4'h0, CODE_PROG_NVMODE});
    setMode(mk(BL_1, 1'b0, 2'b00, 1'b0));
    readRun(1'b0, 8'h33, 1, 0, 1);
    issue(4'b0001, {4'h0, CODE_INIT});
    idle(4);
    `CHK(statusReady, 1'b0)
    waitReady(n);
    `CHK(n < INIT_N + 8, 1'b1)
    readRun(1'b0, 8'h11, 2, 0, 2);
    setMode(mk(BL_4, 1'b0, 2'b00, 1'b0));
    issue(4'b0100, 12'h000, {8'h00, CODE_INIT});
    idle(4);
    `CHK(statusReady, 1'b0)
    waitReady(n);
    `CHK(n < INIT_N + 8, 1'b1)
    readRun(1'b0, 8'h22, 2, 0, 2);
    power_down_reset_n = 1'b0;
    idle(8);
    `CHK(statusReady, 1'b0)
    power_down_reset_n = 1'b1;
    waitReady(n);
    `CHK(n < INIT_N + 8, 1'b1)
    for (int k = 0; k < 4; k++) begin
      setMode(mk(wbl[k], 1'b0, 2'b00, wbm[k]));
      bank = 2'($urandom);
      issue(4'b0011, 12'($urandom));
      issue(4'b0001, {4'h0, CODE_PROG_SETUP});
      weCnt = 0;
      issue(4'b0100, {4'h0, 8'($urandom)}, 16'($urandom) | 16'h0100);
      idle(14);
      `CHK(weCnt, wlen[k])
      $display("write burst of %0d done", wlen[k]);
    end
    close_out();
  end
  // whole run is near 600 cycles; allow about forty times that
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule : nvs_top_tb

// file: hdl/nvs_fifo.sv
`timescale 1ns/100ps
module nvs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // both sides
  nvs_fifo_if.fifo fif
);
  import nvs_pkg::*;
  // depth must be a power of two
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic [AW:0] count;
  logic outValid_q;
  logic [WIDTH-1:0] outData_q;
  logic push;
  logic load;

  assign count = wp_q - rp_q;
  assign fif.inReady = (count != (AW + 1)'(DEPTH));
  assign push = fif.inValid && fif.inReady;
  assign load = (count != '0) && (!outValid_q || fif.outReady);
  assign fif.outValid = outValid_q;
  assign fif.outData = outData_q;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= fif.inData;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (load) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  // read data leave through a register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      outValid_q <= 1'b0;
      outData_q <= '0;
    end else if (load) begin
      outValid_q <= 1'b1;
      outData_q <= mem[rp_q[AW-1:0]];
    end else if (fif.outReady) begin
      outValid_q <= 1'b0;
    end
  end
endmodule : nvs_fifo

// file: hdl/nvs_fifo_if.sv
`timescale 1ns/100ps
interface nvs_fifo_if #(parameter int WIDTH = 16);
  logic inValid;
  logic inReady;
  logic [WIDTH-1:0] inData;
  logic outValid;
  logic outReady;
  logic [WIDTH-1:0] outData;
  modport fifo(input inValid, input inData, input outReady,
               output inReady, output outValid, output outData);
  modport user(output inValid, output inData, output outReady,
               input inReady, input outValid, input outData);
endinterface : nvs_fifo_if

// file: hdl/nvs_pkg.sv
package nvs_pkg;
  // pin and array geometry
  localparam int ADDR_W = 12;
  localparam int BANK_W = 2;
  localparam int COL_W = 8;
  localparam int ROW_W = 12;
  localparam int ARR_W = BANK_W + ROW_W + COL_W;
  localparam int NUM_BANKS = 4;
  localparam logic [ROW_W-1:0] ROW_MASK_X16 = 12'hFFF;
  localparam logic [ROW_W-1:0] ROW_MASK_X32 = 12'h7FF;
  // working mode register layout
  localparam int MODE_W = 12;
  localparam int BL_LSB = 0;
  localparam int BL_W = 3;
  localparam int BT_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_W = 3;
  localparam int OPM_LSB = 7;
  localparam int OPM_W = 2;
  localparam int WBM_BIT = 9;
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h020;
  localparam logic [MODE_W-1:0] NV_MODE_RESET = 12'h020;
  localparam logic [OPM_W-1:0] OPM_NORMAL = 2'h0;
  // burst length codes
  localparam logic [BL_W-1:0] BL_1 = 3'h0;
  localparam logic [BL_W-1:0] BL_2 = 3'h1;
  localparam logic [BL_W-1:0] BL_4 = 3'h2;
  localparam logic [BL_W-1:0] BL_8 = 3'h3;
  localparam logic [BL_W-1:0] BL_FULL = 3'h7;
  // command sequence codes
  localparam logic [7:0] CODE_INIT = 8'hA0;
  localparam logic [7:0] CODE_PROG_SETUP = 8'h40;
  localparam logic [7:0] CODE_PROG_NVMODE = 8'hC0;
  // status
  localparam int STATUS_READY_BIT = 7;
  // initialization time
  localparam int INIT_TIME_NS = 100_000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int INIT_CYCLES = INIT_TIME_NS / CLK_PERIOD_NS;
  // buffering
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    ST_PWRDN = 3'b000,
    ST_INIT = 3'b001,
    ST_IDLE = 3'b010,
    ST_READ = 3'b011,
    ST_WRITE = 3'b100
  } nvs_state_t;

  typedef enum logic [2:0] {
    C_NOP = 3'b000,
    C_ACT = 3'b001,
    C_RD = 3'b010,
    C_WR = 3'b011,
    C_BT = 3'b100,
    C_LCR = 3'b101,
    C_LMR = 3'b110
  } nvs_cmd_t;

  // pins in order cs, ras, cas, we (all active low)
  function automatic nvs_cmd_t nvsDecode(input logic [3:0] pins);
    nvs_cmd_t c;
    c = C_NOP;
    unique case (pins)
      4'b0011: c = C_ACT;
      4'b0101: c = C_RD;
      4'b0100: c = C_WR;
      4'b0110: c = C_BT;
      4'b0001: c = C_LCR;
      4'b0000: c = C_LMR;
      default: c = C_NOP;
    endcase
    return c;
  endfunction : nvsDecode

  // offset mask of the wrap block; reserved codes act as length one
  function automatic logic [COL_W-1:0] nvsLenMask(input logic [BL_W-1:0] code);
    logic [COL_W-1:0] m;
    m = 8'h00;
    unique case (code)
      BL_2: m = 8'h01;
      BL_4: m = 8'h03;
      BL_8: m = 8'h07;
      BL_FULL: m = 8'hFF;
      default: m = 8'h00;
    endcase
    return m;
  endfunction : nvsLenMask

  // column of beat i inside the block selected by the upper start bits
  function automatic logic [COL_W-1:0] nvsColOf(input logic [COL_W-1:0] start,
                                                input logic [COL_W-1:0] i,
                                                input logic [COL_W-1:0] mask,
                                                input logic inter);
    logic [COL_W-1:0] off;
    off = 8'h00;
    if (inter) begin
      off = (start ^ i) & mask;
    end else begin
      off = COL_W'(start + i) & mask;
    end
    return (start & ~mask) | off;
  endfunction : nvsColOf
endpackage : nvs_pkg

// file: hdl/nvs_top.sv
`timescale 1ns/100ps
module nvs_top #(
  parameter int DQ_W = 16,
  parameter int INIT_CYCLES = nvs_pkg::INIT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // command and address pins
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic bank_select_0,
  input wire logic bank_select_1,
  input wire logic [nvs_pkg::ADDR_W-1:0] addr,
  input wire logic power_down_reset_n,
  // data pins
  input wire logic [DQ_W-1:0] dqIn,
  output logic [DQ_W-1:0] dqOut,
  output logic dqOeN,
  // array side
  output logic arrayReq,
  output logic arrayWe,
  output logic [nvs_pkg::ARR_W-1:0] arrayAddr,
  output logic [DQ_W-1:0] arrayWrData,
  input wire logic arrayRdValid,
  input wire logic [DQ_W-1:0] arrayRdData,
  // status
  output logic statusReady
);
  import nvs_pkg::*;

  localparam int INIT_CW = $clog2(INIT_CYCLES + 1);
  localparam logic [ROW_W-1:0] ROW_MASK = (DQ_W == 32) ? ROW_MASK_X32 : ROW_MASK_X16;

  nvs_cmd_t cmd_q;
  logic [BANK_W-1:0] ba_q;
  logic [ADDR_W-1:0] a_q;
  logic [DQ_W-1:0] d_q;
  logic pdrMeta_q;
  logic pdrSync_q;
  logic pdrLast_q;
  nvs_state_t state_q;
  logic [INIT_CW-1:0] initCnt_q;
  logic [MODE_W-1:0] modeReg_q;
  logic [MODE_W-1:0] nvMode_q;
  logic progSetup_q;
  logic [ROW_W-1:0] openRow_q [NUM_BANKS];
  logic [BANK_W-1:0] bank_q;
  logic [COL_W-1:0] colStart_q;
  logic [COL_W-1:0] beat_q;
  logic [LAT_W-1:0] latCnt_q;
  logic [DQ_W-1:0] dqOut_q;
  logic dqOeN_q;
  logic arrayReq_q;
  logic arrayWe_q;
  logic [ARR_W-1:0] arrayAddr_q;
  logic [DQ_W-1:0] arrayWrData_q;
  logic statusReady_q;

  logic pdrRise;
  logic codeValid;
  logic [7:0] code;
  logic startInit;
  logic normalMode;
  logic fullPage;
  logic [COL_W-1:0] rdMask;
  logic [COL_W-1:0] wrMask;
  logic rdInter;
  logic wrInter;
  logic issue;
  logic rdLast;
  logic wrLast;
  logic pop;

  nvs_fifo_if #(.WIDTH(DQ_W)) fifoIf ();

  nvs_fifo #(.WIDTH(DQ_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .fif(fifoIf)
  );

  // command pins are synchronous to mclk, so one register stage suffices
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= C_NOP;
      ba_q <= '0;
      a_q <= '0;
      d_q <= '0;
    end else begin
      cmd_q <= nvsDecode({csN, rasN, casN, weN});
      ba_q <= {bank_select_1, bank_select_0};
      a_q <= addr;
      d_q <= dqIn;
    end
  end

  // the reset pin may move at any time, so it is synchronised
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pdrMeta_q <= 1'b0;
      pdrSync_q <= 1'b0;
      pdrLast_q <= 1'b0;
    end else begin
      pdrMeta_q <= power_down_reset_n;
      pdrSync_q <= pdrMeta_q;
      pdrLast_q <= pdrSync_q;
    end
  end

  assign pdrRise = pdrSync_q && !pdrLast_q;
  assign codeValid = (cmd_q == C_LCR) || ((cmd_q == C_WR) && !progSetup_q);
  assign code = (cmd_q == C_LCR) ? a_q[7:0] : d_q[7:0];
  assign startInit = pdrRise || (pdrSync_q && codeValid && (code == CODE_INIT));
  assign normalMode = (modeReg_q[OPM_LSB +: OPM_W] == OPM_NORMAL);
  assign fullPage = (modeReg_q[BL_LSB +: BL_W] == BL_FULL);
  assign rdMask = nvsLenMask(modeReg_q[BL_LSB +: BL_W]);
  // a full-page read has no interleaved form and length one ignores the type bit
  assign rdInter = modeReg_q[BT_BIT] && !fullPage;
  assign wrInter = modeReg_q[BT_BIT];
  assign wrMask = modeReg_q[WBM_BIT] ? 8'h00 : (fullPage ? 8'h07 : rdMask);
  assign issue = (state_q == ST_READ) && fifoIf.inReady && (cmd_q != C_BT);
  assign rdLast = !fullPage && (beat_q == rdMask);
  assign wrLast = (beat_q == wrMask);
  assign pop = fifoIf.outValid && (latCnt_q == '0);

  assign fifoIf.inValid = arrayRdValid;
  assign fifoIf.inData = arrayRdData;
  assign fifoIf.outReady = (latCnt_q == '0);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_PWRDN;
    end else if (!pdrSync_q) begin
      state_q <= ST_PWRDN;
    end else if (startInit) begin
      state_q <= ST_INIT;
    end else begin
      unique case (state_q)
        ST_PWRDN: state_q <= ST_PWRDN;
        ST_INIT: begin
          if (initCnt_q == INIT_CW'(INIT_CYCLES - 1)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (cmd_q == C_RD && normalMode) begin
            state_q <= ST_READ;
          end else if (cmd_q == C_WR && progSetup_q && wrMask != 8'h00) begin
            state_q <= ST_WRITE;
          end
        end
        ST_READ: begin
          if (cmd_q == C_BT) begin
            state_q <= ST_IDLE;
          end else if (cmd_q == C_RD && normalMode) begin
            state_q <= ST_READ;
          end else if (issue && rdLast) begin
            state_q <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (wrLast) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_PWRDN;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      initCnt_q <= '0;
    end else if (startInit || state_q != ST_INIT) begin
      initCnt_q <= '0;
    end else begin
      initCnt_q <= initCnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      statusReady_q <= 1'b0;
    end else begin
      statusReady_q <= pdrSync_q && !startInit && (state_q != ST_INIT)
                       && (state_q != ST_PWRDN);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      modeReg_q <= MODE_RESET;
    end else if (startInit) begin
      modeReg_q <= nvMode_q;
    end else if (cmd_q == C_LMR && state_q == ST_IDLE) begin
      modeReg_q <= a_q[MODE_W-1:0];
    end
  end

  // a flop stands in for the nonvolatile cell; it only survives while powered
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      nvMode_q <= NV_MODE_RESET;
    end else if (state_q == ST_IDLE && codeValid && code == CODE_PROG_NVMODE) begin
      nvMode_q <= modeReg_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      progSetup_q <= 1'b0;
    end else if (state_q != ST_IDLE) begin
      progSetup_q <= 1'b0;
    end else if (cmd_q == C_WR && progSetup_q) begin
      progSetup_q <= 1'b0;
    end else if (codeValid && code == CODE_PROG_SETUP) begin
      progSetup_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      openRow_q <= '{default: '0};
    end else if (cmd_q == C_ACT && (state_q == ST_IDLE || state_q == ST_READ)) begin
      openRow_q[ba_q] <= a_q & ROW_MASK;
    end
  end

  // a new READ restarts the burst; the row comes from the bank's last ACTIVE
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bank_q <= '0;
      colStart_q <= '0;
      beat_q <= '0;
    end else if ((cmd_q == C_RD && normalMode && (state_q == ST_IDLE || state_q == ST_READ))
                 || (cmd_q == C_WR && progSetup_q && state_q == ST_IDLE)) begin
      bank_q <= ba_q;
      colStart_q <= a_q[COL_W-1:0];
      beat_q <= (cmd_q == C_WR) ? 8'h01 : 8'h00;
    end else if (issue || state_q == ST_WRITE) begin
      beat_q <= beat_q + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      arrayReq_q <= 1'b0;
      arrayWe_q <= 1'b0;
      arrayAddr_q <= '0;
      arrayWrData_q <= '0;
    end else if (state_q == ST_IDLE && cmd_q == C_WR && progSetup_q) begin
      arrayReq_q <= 1'b0;
      arrayWe_q <= 1'b1;
      arrayAddr_q <= {ba_q, openRow_q[ba_q], nvsColOf(a_q[COL_W-1:0], 8'h00, wrMask, wrInter)};
      arrayWrData_q <= d_q;
    end else if (state_q == ST_WRITE) begin
      arrayReq_q <= 1'b0;
      arrayWe_q <= 1'b1;
      arrayAddr_q <= {bank_q, openRow_q[bank_q],
                      nvsColOf(colStart_q, beat_q, wrMask, wrInter)};
      arrayWrData_q <= d_q;
    end else if (issue) begin
      arrayReq_q <= 1'b1;
      arrayWe_q <= 1'b0;
      arrayAddr_q <= {bank_q, openRow_q[bank_q],
                      nvsColOf(colStart_q, beat_q, rdMask, rdInter)};
    end else begin
      arrayReq_q <= 1'b0;
      arrayWe_q <= 1'b0;
    end
  end

  // latency counts from the registered READ; a short setting cannot beat the array path
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      latCnt_q <= '0;
    end else if (cmd_q == C_RD && normalMode && (state_q == ST_IDLE || state_q == ST_READ)) begin
      latCnt_q <= modeReg_q[LAT_LSB +: LAT_W];
    end else if (latCnt_q != '0) begin
      latCnt_q <= latCnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dqOut_q <= '0;
      dqOeN_q <= 1'b1;
    end else begin
      dqOeN_q <= !pop;
      if (pop) begin
        dqOut_q <= fifoIf.outData;
      end
    end
  end

  assign dqOut = dqOut_q;
  assign dqOeN = dqOeN_q;
  assign arrayReq = arrayReq_q;
  assign arrayWe = arrayWe_q;
  assign arrayAddr = arrayAddr_q;
  assign arrayWrData = arrayWrData_q;
  assign statusReady = statusReady_q;
endmodule : nvs_top
